// *** src/ddio_pkg.sv ***
// Package holding constants for the dual discrete I/O port block.
// Assumes a classic Wishbone slave with 32-bit data and word registers.
package ddio_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int WB_AW  = 8;   // Byte address width.
    localparam int WB_DW  = 32;  // Data width.
    localparam int WB_SW  = 4;   // Byte select width.
    localparam int IDX_W  = 6;   // Register index width (address bits 7:2).
    localparam int PORT_W = 8;   // Pins per port.
    localparam int REG_W  = 16;  // Port data register width.

    // ------------------------------------------------------------------
    // Register indexes (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_E_DATA_FIRST  = 6'h10;
    localparam logic [IDX_W-1:0] IDX_E_DATA_SECOND = 6'h12;
    localparam logic [IDX_W-1:0] IDX_E_DIRECTION   = 6'h14;
    localparam logic [IDX_W-1:0] IDX_E_FUNCTION    = 6'h16;
    localparam logic [IDX_W-1:0] IDX_F_DATA_FIRST  = 6'h18;
    localparam logic [IDX_W-1:0] IDX_F_DATA_SECOND = 6'h1a;
    localparam logic [IDX_W-1:0] IDX_F_DIRECTION   = 6'h1c;
    localparam logic [IDX_W-1:0] IDX_F_FUNCTION    = 6'h1e;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int              RMW_BIT       = 3;  // Read-modify-write pin.
    localparam int              MODE_BIT      = 0;  // Port F clock-mode bit.
    localparam logic [7:0]      DIR_RESET     = 8'h00;
    localparam logic [7:0]      FUNC_ALL_ALT  = 8'hff;
    localparam logic [7:0]      FUNC_ALL_IO   = 8'h00;
    localparam logic [7:0]      RMW_MASK      = 8'h08;
    localparam logic [WB_DW-1:0] UNMAPPED_READ = 32'h0000_0000;

endpackage : ddio_pkg

// *** src/ddio_sync.sv ***
// Three-stage input synchroniser with agreement filter for pin inputs.
// Assumes inputs come from outside the clock domain; no reset on the
// stages, so straps pass through while reset is held.
`timescale 1ns/1ps

module ddio_sync #(
    parameter int WIDTH = 18
) (
    // Clock.
    input  wire logic             clk,
    // Asynchronous inputs and their filtered copy.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (WIDTH < 1)
    begin : g_bad_width
        $error("ddio_sync width must be at least one.");
    end

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] out_d;

    // A bit changes only once the second and third stages agree.
    assign out_d = ((stage2_q ~^ stage3_q) & stage3_q)
                 | ((stage2_q ^ stage3_q) & sync_out);

    // Shift chain; the first stage feeds only the second.
    always_ff @(posedge clk)
    begin
        stage1_q <= async_in;
        stage2_q <= stage1_q;
        stage3_q <= stage2_q;
        sync_out <= out_d;
    end

endmodule : ddio_sync

// *** src/ddio_ports.sv ***
// Two 8-bit discrete I/O ports (E and F) with per-pin function select.
// Assumes a classic Wishbone master, pins split into in/out/enable,
// and a bus controller supplying the port E alternate drives.
`timescale 1ns/1ps

module ddio_ports #(
    parameter bit         HAS_BIT3_PIN    = 1'b1,
    parameter bit         HAS_RMW_FUNC    = 1'b1,
    parameter bit         BIT3_READ_VALUE = 1'b0
) (
    // Clock and synchronous reset.
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // Wishbone classic slave.
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [ddio_pkg::WB_AW-1:0]    wb_adr_i,
    input  wire logic [ddio_pkg::WB_SW-1:0]    wb_sel_i,
    input  wire logic [ddio_pkg::WB_DW-1:0]    wb_dat_i,
    output logic      [ddio_pkg::WB_DW-1:0]    wb_dat_o,
    output logic                               wb_ack_o,
    // Reset straps.
    input  wire logic                          port_e_reset_strap,
    input  wire logic                          port_f_reset_strap,
    // Port E pins.
    input  wire logic [ddio_pkg::PORT_W-1:0]   port_e_pin_i,
    output logic      [ddio_pkg::PORT_W-1:0]   port_e_pin_o,
    output logic      [ddio_pkg::PORT_W-1:0]   port_e_pin_oe,
    // Bus controller side of the port E alternate functions.
    input  wire logic [ddio_pkg::PORT_W-1:0]   bus_ctrl_out,
    input  wire logic [ddio_pkg::PORT_W-1:0]   bus_ctrl_oe,
    output logic      [ddio_pkg::PORT_W-1:0]   bus_ctrl_in,
    // Port F pins.
    input  wire logic [ddio_pkg::PORT_W-1:0]   port_f_pin_i,
    output logic      [ddio_pkg::PORT_W-1:0]   port_f_pin_o,
    output logic      [ddio_pkg::PORT_W-1:0]   port_f_pin_oe,
    // Port F alternate inputs toward the core.
    output logic      [7:1]                    irq_level_n,
    output logic                               clock_mode_select_input
);
    import ddio_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (HAS_RMW_FUNC && !HAS_BIT3_PIN)
    begin : g_bad_variant
        $error("Read-modify-write function needs the port E bit 3 pin.");
    end

    // Bits that are fixed to one because the bit 3 pin is absent.
    localparam logic [7:0] E_FIXED = HAS_BIT3_PIN ? 8'h00 : RMW_MASK;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [17:0] sync_in;
    logic [17:0] sync_out;
    logic [7:0]  e_pin_s;
    logic [7:0]  f_pin_s;
    logic        strap_e_s;
    logic        strap_f_s;

    assign sync_in = {port_f_reset_strap, port_e_reset_strap,
                      port_f_pin_i, port_e_pin_i};

    ddio_sync #(
        .WIDTH    (18)
    ) u_sync (
        .clk      (clk),
        .async_in (sync_in),
        .sync_out (sync_out)
    );

    // Split the filtered inputs.
    assign e_pin_s   = sync_out[7:0];
    assign f_pin_s   = sync_out[15:8];
    assign strap_e_s = sync_out[16];
    assign strap_f_s = sync_out[17];

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic              ack_q;
    logic              req;
    logic              wr_take;
    logic [IDX_W-1:0]  idx;
    logic              hit_e_data;
    logic              hit_e_dir;
    logic              hit_e_func;
    logic              hit_f_data;
    logic              hit_f_dir;
    logic              hit_f_func;
    logic [7:0]        wbyte;

    // A write takes effect on the edge at which the master sees ack.
    assign req     = wb_cyc_i & wb_stb_i;
    assign wr_take = req & wb_we_i & ack_q & wb_sel_i[0];
    assign idx     = wb_adr_i[WB_AW-1:2];
    assign wbyte   = wb_dat_i[7:0];

    // Both aliases of a data register decode to the same latch.
    assign hit_e_data = (idx == IDX_E_DATA_FIRST)
                      | (idx == IDX_E_DATA_SECOND);
    assign hit_f_data = (idx == IDX_F_DATA_FIRST)
                      | (idx == IDX_F_DATA_SECOND);
    assign hit_e_dir  = (idx == IDX_E_DIRECTION);
    assign hit_f_dir  = (idx == IDX_F_DIRECTION);
    assign hit_e_func = (idx == IDX_E_FUNCTION);
    assign hit_f_func = (idx == IDX_F_FUNCTION);

    // ------------------------------------------------------------------
    // Function select registers
    // ------------------------------------------------------------------
    logic [7:0] pe_func_q;
    logic [7:0] pe_func_d;
    logic [7:0] pf_func_q;
    logic [7:0] pf_func_d;

    // Reset copies the straps; an absent bit 3 stays one.
    assign pe_func_d = !rst_n ? ({8{strap_e_s}} | E_FIXED)
                     : (wr_take & hit_e_func) ? (wbyte | E_FIXED)
                     : pe_func_q;
    assign pf_func_d = !rst_n ? {8{strap_f_s}}
                     : (wr_take & hit_f_func) ? wbyte
                     : pf_func_q;

    // Function select state.
    always_ff @(posedge clk)
    begin
        pe_func_q <= pe_func_d;
        pf_func_q <= pf_func_d;
    end

    // ------------------------------------------------------------------
    // Direction registers
    // ------------------------------------------------------------------
    logic [7:0] pe_dir_q;
    logic [7:0] pe_dir_d;
    logic [7:0] pf_dir_q;
    logic [7:0] pf_dir_d;

    // Cleared by reset, except that an absent bit 3 stays one; writable at any time.
    assign pe_dir_d = !rst_n ? (DIR_RESET | E_FIXED)
                    : (wr_take & hit_e_dir) ? (wbyte | E_FIXED)
                    : pe_dir_q;
    assign pf_dir_d = !rst_n ? DIR_RESET
                    : (wr_take & hit_f_dir) ? wbyte
                    : pf_dir_q;

    // Direction state.
    always_ff @(posedge clk)
    begin
        pe_dir_q <= pe_dir_d;
        pf_dir_q <= pf_dir_d;
    end

    // ------------------------------------------------------------------
    // Data latches (not reset)
    // ------------------------------------------------------------------
    logic [7:0] pe_data_q;
    logic [7:0] pe_data_d;
    logic [7:0] pf_data_q;
    logic [7:0] pf_data_d;

    // Only the low byte is stored; an absent bit 3 ignores writes.
    assign pe_data_d = (wr_take & hit_e_data)
                     ? ((wbyte & ~E_FIXED) | (pe_data_q & E_FIXED))
                     : pe_data_q;
    assign pf_data_d = (wr_take & hit_f_data) ? wbyte : pf_data_q;

    // Data latch state keeps its value through reset.
    always_ff @(posedge clk)
    begin
        pe_data_q <= pe_data_d;
        pf_data_q <= pf_data_d;
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0]       e_is_input;
    logic [7:0]       f_is_input;
    logic [7:0]       pe_rd;
    logic [7:0]       pe_rd_raw;
    logic [7:0]       pf_rd;
    logic [WB_DW-1:0] rd_word;

    // Discrete inputs return the pin, everything else the latch.
    assign e_is_input = ~pe_func_q & ~pe_dir_q;
    assign f_is_input = ~pf_func_q & ~pf_dir_q;
    assign pe_rd_raw  = (e_is_input & e_pin_s)
                      | (~e_is_input & pe_data_q);
    assign pf_rd      = (f_is_input & f_pin_s)
                      | (~f_is_input & pf_data_q);
    assign pe_rd      = HAS_BIT3_PIN ? pe_rd_raw
                      : {pe_rd_raw[7:4], BIT3_READ_VALUE,
                         pe_rd_raw[2:0]};

    // Register select; upper bits of every register read zero.
    assign rd_word = hit_e_data ? {24'h00_0000, pe_rd}
                   : hit_f_data ? {24'h00_0000, pf_rd}
                   : hit_e_dir  ? {24'h00_0000, pe_dir_q}
                   : hit_f_dir  ? {24'h00_0000, pf_dir_q}
                   : hit_e_func ? {24'h00_0000, pe_func_q}
                   : hit_f_func ? {24'h00_0000, pf_func_q}
                   : UNMAPPED_READ;

    // Answer one cycle after the request; ack lasts one cycle.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack_q    <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            ack_q    <= req & ~ack_q;
            wb_dat_o <= (req & ~ack_q) ? rd_word : wb_dat_o;
        end
    end

    assign wb_ack_o = ack_q;

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    logic [7:0] e_gpio_oe;
    logic [7:0] e_alt_oe;
    logic [7:0] e_alt_out;
    logic [7:0] e_run_oe;
    logic [7:0] e_run_out;
    logic [7:0] e_pin_mask;

    // Bus controller drive; bit 3 forced high without the rmw function.
    assign e_alt_out = HAS_RMW_FUNC ? bus_ctrl_out
                     : (bus_ctrl_out | RMW_MASK);
    assign e_alt_oe  = HAS_RMW_FUNC ? bus_ctrl_oe
                     : (bus_ctrl_oe | RMW_MASK);
    assign e_gpio_oe = ~pe_func_q & pe_dir_q;

    // Function bit picks the source per pin.
    assign e_run_oe  = (pe_func_q & e_alt_oe) | e_gpio_oe;
    assign e_run_out = (pe_func_q & e_alt_out)
                     | (~pe_func_q & pe_data_q);
    assign e_pin_mask = ~E_FIXED;

    // During reset the straps decide between driven-high and floating.
    assign port_e_pin_oe = (!rst_n ? pe_func_q : e_run_oe)
                         & e_pin_mask;
    assign port_e_pin_o  = !rst_n ? FUNC_ALL_ALT : e_run_out;

    // Port F alternates are inputs only, so the driver is off.
    assign port_f_pin_oe = ~pf_func_q & pf_dir_q;
    assign port_f_pin_o  = pf_data_q;

    // ------------------------------------------------------------------
    // Alternate inputs toward the core
    // ------------------------------------------------------------------
    // Bus control inputs, bit 7 size high down to bit 0 byte ack.
    assign bus_ctrl_in = e_pin_s & pe_func_q;

    // Interrupt levels idle high when the pin is in I/O mode.
    assign irq_level_n = f_pin_s[7:1] | ~pf_func_q[7:1];
    assign clock_mode_select_input = f_pin_s[MODE_BIT]
                                   | ~pf_func_q[MODE_BIT];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_f_read_req;
        req && !wb_we_i && hit_f_data && !ack_q;
    endsequence

    property p_e_strap;
        $rose(rst_n) |-> pe_func_q == ({8{$past(strap_e_s)}} | E_FIXED);
    endproperty
    a_e_strap: assert property (p_e_strap)
        else $error("Port E function select missed its strap.");

    property p_f_strap;
        $rose(rst_n) |-> pf_func_q == {8{$past(strap_f_s)}};
    endproperty
    a_f_strap: assert property (p_f_strap)
        else $error("Port F function select missed its strap.");

    property p_dir_write_drives;
        (wr_take && hit_f_dir) |=> port_f_pin_oe
            == ($past(wbyte) & ~pf_func_q);
    endproperty
    a_dir_write_drives: assert property (p_dir_write_drives)
        else $error("Port F direction write did not steer drivers.");

    property p_alias_write;
        (wr_take && idx == IDX_F_DATA_SECOND) |=>
            pf_data_q == $past(wbyte) && port_f_pin_o == $past(wbyte);
    endproperty
    a_alias_write: assert property (p_alias_write)
        else $error("Second port F alias write not stored.");

    property p_f_read;
        s_f_read_req |=> wb_ack_o && wb_dat_o[7:0] ==
            (($past(f_is_input) & $past(f_pin_s))
            | (~$past(f_is_input) & $past(pf_data_q)));
    endproperty
    a_f_read: assert property (p_f_read)
        else $error("Port F read returned the wrong source.");

    property p_upper_zero;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000 ##1 !wb_ack_o;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("Upper read bits not zero or ack too long.");

    property p_latch_hold;
        @(posedge clk) disable iff (1'b0)
        (!rst_n && !(wr_take && hit_f_data)) |=>
            pf_data_q === $past(pf_data_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("Reset disturbed the port F data latch.");

    property p_pe3_absent;
        !HAS_BIT3_PIN |-> pe_func_q[RMW_BIT] && pe_dir_q[RMW_BIT]
            && !port_e_pin_oe[RMW_BIT];
    endproperty
    a_pe3_absent: assert property (p_pe3_absent)
        else $error("Absent port E bit 3 not fixed.");

    property p_rmw_high;
        (!HAS_RMW_FUNC && HAS_BIT3_PIN && pe_func_q[RMW_BIT]) |->
            port_e_pin_oe[RMW_BIT] && port_e_pin_o[RMW_BIT];
    endproperty
    a_rmw_high: assert property (p_rmw_high)
        else $error("Port E bit 3 not driven high.");

    property p_alt_owns;
        (pf_func_q != 8'h00) |-> (port_f_pin_oe & pf_func_q) == 8'h00;
    endproperty
    a_alt_owns: assert property (p_alt_owns)
        else $error("Alternate function pin still driven by I/O.");

endmodule : ddio_ports

// *** bench/ddio_board.sv ***
// Board model for the discrete pins of both ports.
// Assumes the block's pin drives and enables are wired straight in.
`timescale 1ns/1ps

module ddio_board (
    // Block drive and enables.
    input  wire logic [ddio_pkg::PORT_W-1:0] e_drv,
    input  wire logic [ddio_pkg::PORT_W-1:0] e_en,
    input  wire logic [ddio_pkg::PORT_W-1:0] f_drv,
    input  wire logic [ddio_pkg::PORT_W-1:0] f_en,
    // Board levels where the block lets go.
    input  wire logic [ddio_pkg::PORT_W-1:0] e_board,
    input  wire logic [ddio_pkg::PORT_W-1:0] f_board,
    // Resolved pin levels.
    output logic      [ddio_pkg::PORT_W-1:0] e_pin,
    output logic      [ddio_pkg::PORT_W-1:0] f_pin
);
    import ddio_pkg::*;

    // A pin shows the block's level where it drives, else the board's.
    assign e_pin = (e_en & e_drv) | (~e_en & e_board);
    assign f_pin = (f_en & f_drv) | (~f_en & f_board);

endmodule // ddio_board

// *** bench/ddio_ports_tb_top.sv ***
// Self-checking bench for the dual discrete port block.
// Assumes a Wishbone master here and the board model on the pins.
`timescale 1ns/1ps

module ddio_ports_tb_top;
    import ddio_pkg::*;

    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             cyc = 1'b0;
    logic             stb = 1'b0;
    logic             we = 1'b0;
    logic [WB_AW-1:0] adr = 8'h00;
    logic [WB_SW-1:0] sel = 4'h0;
    logic [WB_DW-1:0] wdat = 32'h0;
    logic [WB_DW-1:0] rdat;
    logic [WB_DW-1:0] rd_v;
    logic             ack;
    logic             strap_e = 1'b1;
    logic             strap_f = 1'b0;
    logic [7:0]       brd_e = 8'h0c;
    logic [7:0]       brd_f = 8'h3c;
    logic [7:0]       c_out = 8'h96;
    logic [7:0]       c_en = 8'hf0;
    logic [7:0]       e_pin, e_drv, e_en, f_pin, f_drv, f_en, c_in;
    logic [7:1]       irq_n;
    logic             cmode;
    int               fails = 0;
    int               compares = 0;

    // Clock at 100 ns period.
    always #50 clk = ~clk;

    ddio_ports i_ddio_ports (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .port_e_reset_strap(strap_e),
        .port_f_reset_strap(strap_f), .port_e_pin_i(e_pin),
        .port_e_pin_o(e_drv), .port_e_pin_oe(e_en),
        .bus_ctrl_out(c_out), .bus_ctrl_oe(c_en), .bus_ctrl_in(c_in),
        .port_f_pin_i(f_pin), .port_f_pin_o(f_drv), .port_f_pin_oe(f_en),
        .irq_level_n(irq_n), .clock_mode_select_input(cmode)
    );

    ddio_board i_ddio_board (
        .e_drv(e_drv), .e_en(e_en), .f_drv(f_drv), .f_en(f_en),
        .e_board(brd_e), .f_board(brd_f), .e_pin(e_pin), .f_pin(f_pin)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // One classic cycle, held until ack is sampled high.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        do
        begin
            @(posedge clk);
        end
        while (ack !== 1'b1);
        rd_v = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string n);
        xfer(1'b0, a, 32'h0);
        chk(n, e, rd_v);
    endtask

    // Byte address of a register index.
    function automatic logic [7:0] ad(input logic [IDX_W-1:0] i);
        return {i, 2'b00};
    endfunction

    // Main sequence: reset, port F, port E, second reset.
    initial
    begin
        repeat (10) @(posedge clk);
        chk("e en rst", 32'hff, 32'(e_en));
        chk("e lvl rst", 32'hff, 32'(e_drv));
        rst_n <= 1'b1;
        rd(ad(IDX_E_FUNCTION), 32'hff, "e func");
        rd(ad(IDX_F_FUNCTION), 32'h00, "f func");
        rd(ad(IDX_E_DIRECTION), 32'h00, "e dir");
        rd(ad(IDX_F_DIRECTION), 32'h00, "f dir");
        rd(ad(IDX_F_DATA_SECOND), 32'h3c, "f in");
        wr(ad(IDX_F_DATA_FIRST), 32'ha5a5);
        wr(ad(IDX_F_DIRECTION), 32'hff);
        rd(ad(IDX_F_DATA_SECOND), 32'ha5, "f latch");
        chk("f en", 32'hff, 32'(f_en));
        chk("f lvl", 32'ha5, 32'(f_drv));
        wr(ad(IDX_F_DATA_SECOND), 32'h5a);
        rd(ad(IDX_F_DATA_FIRST), 32'h5a, "f alias");
        wr(ad(IDX_F_DIRECTION), 32'h0f);
        repeat (6) @(posedge clk);
        rd(ad(IDX_F_DATA_FIRST), 32'h3a, "f mixed");
        brd_f <= 8'h54;
        wr(ad(IDX_F_FUNCTION), 32'hff);
        repeat (6) @(posedge clk);
        chk("f en alt", 32'h00, 32'(f_en));
        chk("irq", 32'h2a, 32'(irq_n));
        chk("cmode", 32'h0, 32'(cmode));
        rd(ad(IDX_F_DATA_FIRST), 32'h5a, "f alt rd");
        chk("e en alt", 32'hf0, 32'(e_en));
        chk("e lvl alt", 32'h90, 32'(e_drv & e_en));
        chk("ctl in", 32'h9c, 32'(c_in));
        wr(ad(IDX_E_DATA_FIRST), 32'h33);
        wr(ad(IDX_E_DIRECTION), 32'hff);
        wr(ad(IDX_E_FUNCTION), 32'h00);
        rd(ad(IDX_E_DATA_SECOND), 32'h33, "e latch");
        chk("e en io", 32'hff, 32'(e_en));
        chk("e lvl io", 32'h33, 32'(e_drv));
        wr(8'h04, 32'hff);
        rd(8'h04, 32'h0, "unmapped");
        strap_e <= 1'b0;
        strap_f <= 1'b1;
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        chk("e en rst", 32'h00, 32'(e_en));
        rst_n <= 1'b1;
        rd(ad(IDX_E_FUNCTION), 32'h00, "e func");
        rd(ad(IDX_F_FUNCTION), 32'hff, "f func");
        rd(ad(IDX_E_DIRECTION), 32'h00, "e dir");
        rd(ad(IDX_F_DATA_FIRST), 32'h5a, "f kept");
        results();
    end

    // Watchdog: the tests need about a hundred cycles.
    initial
    begin
        repeat (3000) @(posedge clk);
        fails++;
        $display("CHECK FAILED watchdog expected end seen timeout");
        results();
    end

endmodule // ddio_ports_tb_top
